// file: hdl/frh_pkg.sv
// What this block does
// - after program setup the host writes reset twice in a row
// - after any other command a single reset write suffices
// - host always issues reset twice, needing no program-setup tracking
// - auto-select holds until another valid command such as reset
// - parallel erased memories are verified one by one
// - a verified memory gets a masking read command and stops erasing
// - after the program pulse time the host writes program verify
package frh_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_SIG_A = 8'h80;
    localparam logic [7:0] CMD_SIG_B = 8'h90;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [17:0] ADDR_MFR = 18'h0_0000;
    localparam logic [17:0] ADDR_DEV = 18'h0_0001;
    // ------------------------------------------------------------
    // timing, 100 MHz clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_NS = 50;
    localparam int PROG_PULSE_US = 10;
    localparam int RECOVERY_US = 6;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_PULSE_CYC = PROG_PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC = RECOVERY_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    // ------------------------------------------------------------
    // user request and bus carrier
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FRH_OP_READ = 3'b000,
        FRH_OP_RESET = 3'b001,
        FRH_OP_SIG = 3'b010,
        FRH_OP_PROGRAM = 3'b011,
        FRH_OP_MASK = 3'b100
    } frh_op_t;
    typedef struct packed {
        frh_op_t op;
        logic [17:0] addr;
        logic [7:0] data;
    } frh_req_t;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [17:0] addr;
        logic [7:0] dq_out;
        logic dq_oe_n;
    } frh_bus_t;
endpackage

// file: hdl/frh_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for the data pins coming back from the memory
module frh_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: hdl/frh_host.sv
`timescale 1ns/1ns
// host controller driving a byte-wide command-register flash over its pins
module frh_host (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // user request
    input wire logic req_valid,
    input wire frh_pkg::frh_req_t req,
    output logic req_ready,
    // user answer
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_fail,
    // memory pins
    output frh_pkg::frh_bus_t bus,
    input wire logic [7:0] dq_in,
    output logic address_line_nine_high,
    output logic vpp_high
);
    typedef enum logic [3:0] {
        FRH_IDLE = 4'b0000,
        FRH_WR_LO = 4'b0001,
        FRH_WR_HI = 4'b0010,
        FRH_RD_LO = 4'b0011,
        FRH_WAIT = 4'b0100,
        FRH_NEXT = 4'b0101,
        FRH_DONE = 4'b0110
    } frh_state_t;

    localparam int CNT_W_L = frh_pkg::CNT_W;
    frh_state_t state;
    frh_pkg::frh_req_t cur;
    logic [2:0] step;
    logic [CNT_W_L-1:0] cnt;
    logic [7:0] dq_sync;

    frh_sync #(.W(8)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d(dq_in),
        .q(dq_sync)
    );

    // ------------------------------------------------------------
    // sequence decoding
    // ------------------------------------------------------------
    // byte written at a given step; read steps ignore it
    function automatic logic [7:0] step_byte(input frh_pkg::frh_op_t op, input logic [2:0] s,
                                             input logic [7:0] d);
        step_byte = frh_pkg::CMD_READ;
        case (op)
            frh_pkg::FRH_OP_RESET:
                step_byte = frh_pkg::CMD_RESET;
            frh_pkg::FRH_OP_SIG:
                step_byte = frh_pkg::CMD_SIG_B;
            frh_pkg::FRH_OP_MASK:
                step_byte = frh_pkg::CMD_READ;
            frh_pkg::FRH_OP_PROGRAM:
                case (s)
                    3'd0: step_byte = frh_pkg::CMD_PROG_SETUP;
                    3'd1: step_byte = d;
                    3'd2: step_byte = frh_pkg::CMD_PROG_VERIFY;
                    default: step_byte = frh_pkg::CMD_RESET;
                endcase
            default: step_byte = frh_pkg::CMD_READ;
        endcase
    endfunction

    // does the step write (1) or read (0)
    function automatic logic step_is_write(input frh_pkg::frh_op_t op, input logic [2:0] s);
        case (op)
            frh_pkg::FRH_OP_READ: step_is_write = 1'b0;
            frh_pkg::FRH_OP_SIG: step_is_write = (s == 3'd0);
            frh_pkg::FRH_OP_PROGRAM: step_is_write = (s != 3'd3);
            default: step_is_write = 1'b1;
        endcase
    endfunction

    // number of the last step of each operation
    function automatic logic [2:0] last_step(input frh_pkg::frh_op_t op);
        case (op)
            frh_pkg::FRH_OP_RESET: last_step = 3'd1;
            frh_pkg::FRH_OP_SIG: last_step = 3'd1;
            frh_pkg::FRH_OP_PROGRAM: last_step = 3'd5;
            default: last_step = 3'd0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // the strobe is held low a full STROBE_CYC so address settles before
    // the falling edge and data before the rising edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= FRH_IDLE;
            cur <= '0;
            step <= 3'd0;
            cnt <= '0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_fail <= 1'b0;
            bus <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0,
                     dq_out: 8'h00, dq_oe_n: 1'b1};
            vpp_high <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            case (state)
                FRH_IDLE:
                begin
                    bus.ce_n <= 1'b1;
                    bus.oe_n <= 1'b1;
                    bus.we_n <= 1'b1;
                    bus.dq_oe_n <= 1'b1;
                    if (req_valid && !req_ready)
                    begin
                        req_ready <= 1'b1;
                        cur <= req;
                        // address settles a cycle before either strobe falls
                        bus.addr <= req.addr;
                        step <= 3'd0;
                        rsp_fail <= 1'b0;
                        // supply raised only for program, low otherwise
                        vpp_high <= (req.op == frh_pkg::FRH_OP_PROGRAM);
                        state <= FRH_NEXT;
                    end
                end
                FRH_NEXT:
                begin
                    cnt <= CNT_W_L'(frh_pkg::STROBE_CYC);
                    bus.ce_n <= 1'b0;
                    if (step_is_write(cur.op, step))
                    begin
                        bus.we_n <= 1'b0;
                        bus.oe_n <= 1'b1;
                        bus.dq_out <= step_byte(cur.op, step, cur.data);
                        bus.dq_oe_n <= 1'b0;
                        state <= FRH_WR_LO;
                    end
                    else
                    begin
                        bus.oe_n <= 1'b0;
                        bus.we_n <= 1'b1;
                        bus.dq_oe_n <= 1'b1;
                        state <= FRH_RD_LO;
                    end
                end
                FRH_WR_LO:
                begin
                    cnt <= cnt - 1'b1;
                    if (cnt == '0)
                    begin
                        bus.we_n <= 1'b1;
                        state <= FRH_WR_HI;
                    end
                end
                FRH_WR_HI:
                begin
                    bus.ce_n <= 1'b1;
                    bus.dq_oe_n <= 1'b1;
                    // program pulse follows the program data write, recovery time the verify command
                    if (cur.op == frh_pkg::FRH_OP_PROGRAM && step == 3'd1)
                        cnt <= CNT_W_L'(frh_pkg::PROG_PULSE_CYC);
                    else if (cur.op == frh_pkg::FRH_OP_PROGRAM && step == 3'd2)
                        cnt <= CNT_W_L'(frh_pkg::RECOVERY_CYC);
                    else
                        cnt <= '0;
                    state <= FRH_WAIT;
                end
                FRH_RD_LO:
                begin
                    cnt <= cnt - 1'b1;
                    // synchroniser delay is covered by the long strobe
                    if (cnt == '0)
                    begin
                        rsp_data <= dq_sync;
                        bus.oe_n <= 1'b1;
                        bus.ce_n <= 1'b1;
                        // verify read: this memory judged on its own
                        if (cur.op == frh_pkg::FRH_OP_PROGRAM)
                            rsp_fail <= (dq_sync != cur.data);
                        cnt <= '0;
                        state <= FRH_WAIT;
                    end
                end
                FRH_WAIT:
                begin
                    cnt <= cnt - 1'b1;
                    if (cnt == '0)
                    begin
                        if (step == last_step(cur.op))
                            state <= FRH_DONE;
                        else
                        begin
                            step <= step + 3'd1;
                            state <= FRH_NEXT;
                        end
                    end
                end
                FRH_DONE:
                begin
                    rsp_valid <= 1'b1;
                    vpp_high <= 1'b0;
                    state <= FRH_IDLE;
                end
                default: state <= FRH_IDLE;
            endcase
        end
    end

    // in-system signature reads use the command, never the high voltage
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            address_line_nine_high <= 1'b0;
        else
            address_line_nine_high <= 1'b0;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_one_strobe;
        @(posedge clk) disable iff (!nrst) !(!bus.we_n && !bus.oe_n);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("we and oe both low");
    property p_drive_on_write;
        @(posedge clk) disable iff (!nrst) !bus.we_n |-> !bus.dq_oe_n && !bus.ce_n;
    endproperty
    a_drive_on_write: assert property (p_drive_on_write) else $error("write undriven");
    property p_vpp_low_no_prog;
        @(posedge clk) disable iff (!nrst)
            (!bus.we_n && bus.dq_out == frh_pkg::CMD_PROG_SETUP) |-> vpp_high;
    endproperty
    a_vpp_low_no_prog: assert property (p_vpp_low_no_prog)
        else $error("prog at low supply");
    property p_reset_twice;
        @(posedge clk) disable iff (!nrst)
            (state == FRH_WR_HI && cur.op == frh_pkg::FRH_OP_RESET && step == 3'd0)
            |-> ##[1:20] (state == FRH_WR_LO && bus.dq_out == frh_pkg::CMD_RESET);
    endproperty
    a_reset_twice: assert property (p_reset_twice) else $error("single reset");
    // covers the first strobe cycle too, so the address must settle before it
    property p_addr_stable;
        @(posedge clk) disable iff (!nrst)
            (state == FRH_WR_LO || state == FRH_RD_LO) |-> $stable(bus.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("addr moved in strobe");
    property p_no_hv_addr;
        @(posedge clk) disable iff (!nrst) !address_line_nine_high;
    endproperty
    a_no_hv_addr: assert property (p_no_hv_addr) else $error("high voltage on address");
    property p_verify_after_pulse;
        @(posedge clk) disable iff (!nrst)
            (state == FRH_WR_HI && cur.op == frh_pkg::FRH_OP_PROGRAM && step == 3'd1)
            |=> (state == FRH_WAIT)[*8];
    endproperty
    a_verify_after_pulse: assert property (p_verify_after_pulse)
        else $error("pulse cut short");
    property p_mask_is_read_cmd;
        @(posedge clk) disable iff (!nrst)
            (state == FRH_WR_LO && cur.op == frh_pkg::FRH_OP_MASK)
            |-> bus.dq_out == frh_pkg::CMD_READ;
    endproperty
    a_mask_is_read_cmd: assert property (p_mask_is_read_cmd)
        else $error("bad mask code");
    c_program: cover property (@(posedge clk) state == FRH_DONE
                               && cur.op == frh_pkg::FRH_OP_PROGRAM);
    c_sig: cover property (@(posedge clk) state == FRH_DONE && cur.op == frh_pkg::FRH_OP_SIG);
    c_reset: cover property (@(posedge clk) state == FRH_DONE
                             && cur.op == frh_pkg::FRH_OP_RESET);
endmodule

// file: tb/frh_flash_model.sv
`timescale 1ns/1ns
// behavioural byte-wide flash with a command register, seen from its pins
module frh_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'hC3 // arbitrary value
) (
    // pins driven by the host
    input wire frh_pkg::frh_bus_t bus,
    input wire logic address_line_nine_high,
    input wire logic vpp_high,
    // data pins as the host sees them
    output logic [7:0] dq
);
    // ------------------------------------------------------------
    // state and array
    // ------------------------------------------------------------
    typedef enum logic [2:0] {FM_READ, FM_SIG, FM_SETUP, FM_PROG, FM_VERIFY} frh_mode_t;
    frh_mode_t mode = FM_READ;
    logic [7:0] mem [logic [17:0]];
    logic [17:0] wr_addr = 18'h0_0000;
    logic [7:0] rd_val;
    logic [7:0] last = 8'h00;

    // unwritten cells read as erased
    function automatic logic [7:0] rd(input logic [17:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction

    // ------------------------------------------------------------
    // write cycles
    // ------------------------------------------------------------
    // address latched on strobe fall; select may fall in the same step,
    // so it is judged at the rising edge, where it has settled
    always @(negedge bus.we_n)
        wr_addr = bus.addr;
    // data latched and decoded on strobe rise
    always @(posedge bus.we_n)
        if (!bus.ce_n && bus.oe_n)
        begin
            if (mode == FM_SETUP)
            begin
                // cells only go from one to zero, so ff leaves them alone
                if (vpp_high)
                    mem[wr_addr] = rd(wr_addr) & dq;
                mode = FM_PROG;
            end
            else
                case (dq)
                    8'h80, 8'h90: mode = FM_SIG;
                    8'h40: mode = FM_SETUP;
                    8'hC0: mode = FM_VERIFY;
                    8'hFF, 8'h00: mode = FM_READ;
                    default: mode = mode;
                endcase
        end

    // ------------------------------------------------------------
    // read cycles
    // ------------------------------------------------------------
    // signature on command or on raised address line nine
    always @*
    begin
        if (address_line_nine_high || mode == FM_SIG)
            rd_val = bus.addr[0] ? DEV_CODE : MFR_CODE;
        else
            rd_val = rd(bus.addr);
    end
    // no pull-up on dq, so a released bus shows the inverse of the last byte
    always @(posedge bus.oe_n)
        last <= rd_val;
    assign dq = !bus.dq_oe_n ? bus.dq_out : (!bus.ce_n && !bus.oe_n) ? rd_val : ~last;
endmodule

// file: tb/tb_flash_reset_autoselect_cmd.sv
`timescale 1ns/1ns
// self-checking bench for the flash host controller
module tb_flash_reset_autoselect_cmd;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {logic [1:0] kind; logic [7:0] data; logic fail;} frh_note_t;
    localparam logic [7:0] MFR = 8'h5A; // arbitrary value
    localparam logic [7:0] DEV = 8'hC3; // arbitrary value
    localparam int N_OPS = 40;
    logic clk = 1'b0;
    logic nrst;
    logic req_valid;
    frh_pkg::frh_req_t req;
    logic req_ready, rsp_valid, rsp_fail, address_line_nine_high, vpp_high;
    logic [7:0] rsp_data, dq_in, d, exp_b;
    frh_pkg::frh_bus_t bus;
    frh_note_t note_q[$];
    frh_note_t n_got;
    logic [7:0] shadow [32];
    logic [31:0] u;
    logic [17:0] a;
    int err_count = 0;
    int checks = 0;

    frh_host dut_u (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_fail(rsp_fail), .bus(bus), .dq_in(dq_in),
        .address_line_nine_high(address_line_nine_high), .vpp_high(vpp_high));
    frh_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) model_u (.bus(bus),
        .address_line_nine_high(address_line_nine_high), .vpp_high(vpp_high), .dq(dq_in));

    // 100 MHz clock
    initial
        forever #5 clk = ~clk;

    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // driver: note the expectation, hold the request until taken
    // ------------------------------------------------------------
    task automatic do_op(input frh_pkg::frh_op_t op, input logic [17:0] ad,
            input logic [7:0] dat, input frh_note_t n);
        int t;
        note_q.push_back(n);
        req_valid = 1'b1;
        req = '{op: op, addr: ad, data: dat};
        t = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && t < 100)
        begin
            @(negedge clk);
            t++;
        end
        req_valid = 1'b0;
        // bounded wait; a program op is about 1700 cycles
        while (rsp_valid !== 1'b1 && t < 5000)
        begin
            @(negedge clk);
            t++;
        end
        if (t >= 5000)
        begin
            err_count++;
            $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end
        @(negedge clk);
    endtask
    // signature read, then leave signature mode through reset
    task automatic sig_pair(input logic s);
        do_op(frh_pkg::FRH_OP_SIG, {17'h0_0000, s}, 8'h00,
              '{2'd1, s ? DEV : MFR, 1'b0});
        do_op(frh_pkg::FRH_OP_RESET, 18'h0_0000, 8'h00, '{2'd0, 8'h00, 1'b0});
    endtask

    // ------------------------------------------------------------
    // monitor: each answer takes the oldest note
    // ------------------------------------------------------------
    always @(negedge clk)
        if (rsp_valid === 1'b1)
        begin
            if (note_q.size() == 0)
            begin
                err_count++;
                $display("unexpected answer at %0t: got %h expected %h", $time, rsp_data, 8'h00);
            end
            else
            begin
                n_got = note_q.pop_front();
                if (n_got.kind != 2'd0)
                    cmp_data(rsp_data, n_got.data);
                if (n_got.kind == 2'd2)
                    cmp_bit(rsp_fail, n_got.fail);
            end
        end

    // watchdog, well beyond the longest expected run
    initial
    begin
        #1_000_000;
        err_count++;
        $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        finish_test;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req = '0;
        void'($urandom(32'habdc));
        foreach (shadow[i])
            shadow[i] = 8'hFF;
        repeat (8) @(negedge clk);
        cmp_bit(bus.we_n, 1'b1);
        cmp_bit(bus.dq_oe_n, 1'b1);
        nrst = 1'b1;
        @(negedge clk);
        // erased array readable with no command first
        do_op(frh_pkg::FRH_OP_READ, 18'h3_FFF5, 8'h00, '{2'd1, 8'hFF, 1'b0});
        sig_pair(1'b0);
        sig_pair(1'b1);
        // random mix over two small address clusters to force overlaps
        for (int i = 0; i < N_OPS; i++)
        begin
            u = $urandom;
            a = {u[4] ? 14'h3FFF : 14'h0000, u[3:0]};
            case ($urandom_range(4, 0))
                0: do_op(frh_pkg::FRH_OP_READ, a, 8'h00, '{2'd1, shadow[u[4:0]], 1'b0});
                1:
                begin
                    d = (u[9:8] == 2'b00) ? 8'hFF : u[31:24];
                    exp_b = shadow[u[4:0]] & d;
                    do_op(frh_pkg::FRH_OP_PROGRAM, a, d, '{2'd2, exp_b, exp_b !== d});
                    shadow[u[4:0]] = exp_b;
                end
                2: do_op(frh_pkg::FRH_OP_RESET, a, 8'h00, '{2'd0, 8'h00, 1'b0});
                3: do_op(frh_pkg::FRH_OP_MASK, a, 8'h00, '{2'd0, 8'h00, 1'b0});
                default: sig_pair(u[0]);
            endcase
            cmp_bit(vpp_high, 1'b0);
            cmp_bit(address_line_nine_high, 1'b0);
            cmp_bit(bus.ce_n, 1'b1);
        end
        cmp_bit(note_q.size() == 0, 1'b1);
        finish_test;
    end
endmodule
